// ==== hdl/urd_rx_dma.sv ====
/*
  urd_rx_dma: channel definition logic for the receive transfer channel,
  moving received bytes into X/Y buffers, with an AXI4-Lite register port.
  Assumes receiver strobes, time-out expiry and the buffer manager pick
  are synchronous to aclk; descriptor count is stable while enabled.
*/
`timescale 1ns/10ps

// Overview of operation
// R01: pointer field selects endpoint descriptor set
// R02: direction bit reads one, writes ignored
// R03: software buffer pick used only in burst
// R04: pick zero means X, one means Y
// R05: burst stops at zero count or error
// R06: burst end interrupts on enable fall
// R07: software sets buffer pick before burst start
// R08: continuous mode alternates X and Y buffers
// R09: buffer manager drives pick in continuous
// R10: continuous keeps receiving until termination
// R11: continuous time-out halts, updates, interrupts
// R12: receiver error halts, updates, no interrupt
// R13: software sets enable, channel clears it
// R14: enable fall interrupts when allowed
// R15: irq disallowed keeps enable on time-out
// R16: halt writes count back, clears not-acknowledge
module urd_rx_dma
  import urd_pkg::*;
(
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write address / data / response
  input  wire logic [URD_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]            awprot,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [URD_DATA_W-1:0] wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  // axi4-lite read
  input  wire logic [URD_ADDR_W-1:0] araddr,
  input  wire logic [2:0]            arprot,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [URD_DATA_W-1:0]      rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  // uart receiver
  input  wire logic                  rx_valid,
  input  wire logic [7:0]            rx_data,
  input  wire logic                  rx_error,
  input  wire logic                  timeout_expired,
  // usb buffer manager
  input  wire logic                  ubm_buffer_pick,
  output logic                       buf_swap,
  // endpoint descriptor block
  input  wire logic [URD_CNT_W-1:0]  desc_count,
  output logic [URD_PTR_W-1:0]       desc_sel,
  output logic                       desc_wb_valid,
  output logic [URD_CNT_W-1:0]       desc_wb_count,
  output logic                       nak_clear,
  // sram write side
  output logic                       sram_we,
  output logic [7:0]                 sram_data,
  output logic                       sram_buf_y,
  // interrupt
  output logic                       irq
);

  // bus state
  logic [URD_ADDR_W-1:0] awaddr_q;
  logic [7:0]            wbyte_q;
  logic                  wstrb0_q;
  logic                  have_both;
  logic                  wr_fire;
  logic                  aw_hs, w_hs, ar_hs;
  // channel state
  logic [URD_PTR_W-1:0]  ptr_q;
  logic                  pick_q, cont_q, allow_q, en_q, en_d;
  logic [URD_ST_W-1:0]   stat_q, stat_d, mask_q, stat_set;
  urd_cause_e            cause_q;
  logic                  wr_chdef, wr_stat, wr_mask;
  logic                  take, halt_cnt, halt_err, halt_tout, halt;
  logic                  reload, en_fall, start, cur_pick;
  logic [URD_CNT_W-1:0]  cnt;
  logic                  cnt_zero, cnt_last;
  logic [7:0]            chdef_rd;
  logic [URD_DATA_W-1:0] rd_mux;
  logic                  rd_hit;

  // handshakes and write decode
  assign aw_hs     = awvalid && awready;
  assign w_hs      = wvalid && wready;
  assign ar_hs     = arvalid && arready;
  assign have_both = !awready && !wready;
  assign wr_fire   = have_both && !bvalid;
  assign wr_chdef  = wr_fire && wstrb0_q && (awaddr_q == URD_CHDEF_ADDR);
  assign wr_stat   = wr_fire && wstrb0_q && (awaddr_q == URD_STAT_ADDR);
  assign wr_mask   = wr_fire && wstrb0_q && (awaddr_q == URD_MASK_ADDR);

  // write channels taken in either order, answered once both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready  <= 1'b1;
      wready   <= 1'b1;
      bvalid   <= 1'b0;
      bresp    <= URD_RESP_OKAY;
      awaddr_q <= 16'h0000;
      wbyte_q  <= 8'h00;
      wstrb0_q <= 1'b0;
    end else begin
      if (aw_hs) begin
        awaddr_q <= awaddr;
        awready  <= 1'b0;
      end
      if (w_hs) begin
        wbyte_q  <= wdata[7:0];
        wstrb0_q <= wstrb[0];
        wready   <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= (wr_chdef || wr_stat || wr_mask ||
                   (awaddr_q == URD_CHDEF_ADDR) ||
                   (awaddr_q == URD_STAT_ADDR) ||
                   (awaddr_q == URD_MASK_ADDR)) ?
                  URD_RESP_OKAY : URD_RESP_DECERR;
      end else if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // read decode; direction bit fixed at one
  assign cur_pick = cont_q ? ubm_buffer_pick : pick_q;
  assign chdef_rd = {en_q, allow_q, cont_q, cur_pick, 1'b1, ptr_q}; // R02
  assign rd_hit   = (araddr == URD_CHDEF_ADDR) ||
                    (araddr == URD_STAT_ADDR) || (araddr == URD_MASK_ADDR);
  assign rd_mux   = (araddr == URD_CHDEF_ADDR) ? {24'h000000, chdef_rd} :
                    (araddr == URD_STAT_ADDR) ?
                      {26'h0, cause_q, 2'b00, stat_q} :
                    (araddr == URD_MASK_ADDR) ? {30'h0, mask_q} :
                    32'h00000000;

  // read channel, one answer per address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= URD_RESP_OKAY;
    end else if (ar_hs) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_mux;
      rresp   <= rd_hit ? URD_RESP_OKAY : URD_RESP_DECERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // transfer events
  assign take      = en_q && rx_valid && !rx_error && !cnt_zero;
  assign halt_cnt  = take && cnt_last && !cont_q;                // R05
  assign halt_err  = en_q && rx_error;                           // R05 R12
  assign halt_tout = en_q && timeout_expired && allow_q;         // R11 R15
  assign halt      = halt_cnt || halt_err || halt_tout;
  assign start     = wr_chdef && wbyte_q[URD_EN_BIT] && !en_q;   // R13
  assign reload    = start || (take && cnt_last && cont_q);      // R10
  assign en_d      = halt ? 1'b0 :                               // R13
                     wr_chdef ? wbyte_q[URD_EN_BIT] : en_q;
  assign en_fall   = en_q && !en_d;

  // sticky status: enable fall when allowed and not from error, time-out expiry
  assign stat_set[URD_ST_DONE] = en_fall && allow_q && !halt_err; // R06 R14
  assign stat_set[URD_ST_TOUT] = en_q && timeout_expired;
  assign stat_d = (stat_q & ~(wr_stat ? wbyte_q[1:0] : 2'b00)) | stat_set;

  urd_byte_count u_count (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .load     (reload),
    .load_val (desc_count),
    .dec      (take),
    .count_q  (cnt),
    .zero     (cnt_zero),
    .last     (cnt_last)
  );

  // channel definition fields; pick ignored while continuous
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_q   <= URD_PTR_RST;
      pick_q  <= 1'b0;
      cont_q  <= 1'b0;
      allow_q <= 1'b0;
      en_q    <= 1'b0;
    end else begin
      en_q <= en_d;
      if (wr_chdef) begin
        ptr_q   <= wbyte_q[URD_PTR_W-1:0];                       // R01
        cont_q  <= wbyte_q[URD_CONT_BIT];
        allow_q <= wbyte_q[URD_ALLOW_BIT];
        if (!wbyte_q[URD_CONT_BIT])
          pick_q <= wbyte_q[URD_PICK_BIT];                       // R03
      end
    end
  end

  // status, mask, cause and interrupt line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q  <= URD_STAT_RST;
      mask_q  <= URD_MASK_RST;
      cause_q <= URD_CAUSE_NONE;
      irq     <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq    <= |(stat_q & mask_q);
      if (wr_mask)
        mask_q <= wbyte_q[1:0];
      if (halt_err)
        cause_q <= URD_CAUSE_ERR;
      else if (halt_tout)
        cause_q <= URD_CAUSE_TOUT;
      else if (halt_cnt)
        cause_q <= URD_CAUSE_COUNT;
    end
  end

  // data path to buffers and descriptor update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sram_we       <= 1'b0;
      sram_data     <= 8'h00;
      sram_buf_y    <= 1'b0;
      buf_swap      <= 1'b0;
      desc_sel      <= URD_PTR_RST;
      desc_wb_valid <= 1'b0;
      desc_wb_count <= URD_CNT_RST;
      nak_clear     <= 1'b0;
    end else begin
      sram_we       <= take;
      sram_data     <= rx_data;
      sram_buf_y    <= cur_pick;                      // R03 R04 R09
      buf_swap      <= take && cnt_last && cont_q;    // R08
      desc_sel      <= ptr_q;                         // R01
      desc_wb_valid <= en_fall;                       // R16
      desc_wb_count <= halt_cnt ? 8'h00 : cnt;
      nak_clear     <= en_fall;                       // R16
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_cont_last;
    en_q && cont_q && take && cnt_last && !halt_tout && !wr_chdef;
  endsequence
  sequence s_swap_on;
    buf_swap && sram_we && en_q;
  endsequence

  dir_bit_read_a: assert property ( // R02
    ar_hs && araddr == URD_CHDEF_ADDR |=> rdata[URD_DIR_BIT])
    else $error("direction bit read back as zero");
  desc_sel_follow_a: assert property ( // R01
    ##1 desc_sel == $past(ptr_q))
    else $error("descriptor select lags pointer");
  burst_buf_pick_a: assert property ( // R04
    take && !cont_q |=> sram_we && sram_buf_y == $past(pick_q))
    else $error("burst byte sent to wrong buffer");
  cont_buf_pick_a: assert property ( // R09
    take && cont_q |=> sram_buf_y == $past(ubm_buffer_pick))
    else $error("continuous byte ignores manager pick");
  burst_stop_a: assert property ( // R05
    en_q && !cont_q && take && cnt_last |=> !en_q && desc_wb_valid &&
    desc_wb_count == 8'h00)
    else $error("burst did not stop at zero count");
  cont_swap_go_a: assert property ( // R10
    s_cont_last |=> s_swap_on ##0 (cnt == $past(desc_count)))
    else $error("continuous mode did not reload and swap");
  err_quiet_a: assert property ( // R12
    halt_err |=> !en_q && !$rose(stat_q[URD_ST_DONE]) && desc_wb_valid)
    else $error("receiver error stop wrongly flagged");
  fall_irq_a: assert property ( // R14
    en_q && !halt_err && allow_q ##1 !en_q |-> stat_q[URD_ST_DONE])
    else $error("enable fall did not set done");
  tout_keep_a: assert property ( // R15
    en_q && timeout_expired && !allow_q && !rx_error && !wr_chdef &&
    !halt_cnt |=> en_q)
    else $error("time-out cleared enable with irq off");
  halt_update_a: assert property ( // R16
    $fell(en_q) |-> desc_wb_valid && nak_clear)
    else $error("halt did not update descriptor");

endmodule // urd_rx_dma

// ==== hdl/urd_pkg.sv ====
/*
  urd_pkg: register map, field positions, reset values and codes for the
  receive-side channel logic of a serial-to-buffer transfer engine.
  Assumes a 32-bit AXI4-Lite register bus with 16-bit byte addresses.
*/
package urd_pkg;

  // bus geometry
  localparam int          URD_ADDR_W      = 16;
  localparam int          URD_DATA_W      = 32;
  localparam int          URD_CNT_W       = 8;

  // register byte addresses
  localparam logic [15:0] URD_CHDEF_ADDR  = 16'hFFE4;
  localparam logic [15:0] URD_STAT_ADDR   = 16'hFFF0;
  localparam logic [15:0] URD_MASK_ADDR   = 16'hFFF4;

  // channel definition fields
  localparam int          URD_PTR_LSB     = 0;
  localparam int          URD_PTR_W       = 3;
  localparam int          URD_DIR_BIT     = 3;
  localparam int          URD_PICK_BIT    = 4;
  localparam int          URD_CONT_BIT    = 5;
  localparam int          URD_ALLOW_BIT   = 6;
  localparam int          URD_EN_BIT      = 7;

  // reset values
  localparam logic [2:0]  URD_PTR_RST     = 3'h0;
  localparam logic [7:0]  URD_CNT_RST     = 8'h00;
  localparam logic [1:0]  URD_STAT_RST    = 2'h0;
  localparam logic [1:0]  URD_MASK_RST    = 2'h0;

  // status / mask bits, cause field
  localparam int          URD_ST_DONE     = 0;
  localparam int          URD_ST_TOUT     = 1;
  localparam int          URD_ST_W        = 2;
  localparam int          URD_CAUSE_LSB   = 4;

  // bus responses
  localparam logic [1:0]  URD_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  URD_RESP_DECERR = 2'h3;

  // why the channel last halted on count, time-out or error
  typedef enum logic [1:0] {
    URD_CAUSE_NONE  = 2'b00,
    URD_CAUSE_COUNT = 2'b01,
    URD_CAUSE_TOUT  = 2'b10,
    URD_CAUSE_ERR   = 2'b11
  } urd_cause_e;

endpackage

// ==== hdl/urd_byte_count.sv ====
/*
  urd_byte_count: remaining byte counter of the receive channel.
  Assumes load and dec come from the channel logic in the same clock
  domain; load wins over dec.
*/
`timescale 1ns/10ps
module urd_byte_count
  import urd_pkg::*;
(
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // control
  input  wire logic                 load,
  input  wire logic [URD_CNT_W-1:0] load_val,
  input  wire logic                 dec,
  // state
  output logic      [URD_CNT_W-1:0] count_q,
  output logic                      zero,
  output logic                      last
);

  logic [URD_CNT_W-1:0] count_d;

  // next count: reload beats decrement
  assign count_d = load ? load_val :
                   (dec && !zero) ? count_q - 8'h01 : count_q;
  assign zero    = (count_q == 8'h00);
  assign last    = (count_q == 8'h01);

  // count register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= URD_CNT_RST;
    end else begin
      count_q <= count_d;
    end
  end

endmodule // urd_byte_count

// ==== verif/urd_far_model.sv ====
/*
  urd_far_model: serial receiver and buffer manager facing the channel.
  Assumes bench commands change by non-blocking assignment after aclk.
*/
`timescale 1ns/10ps
module urd_far_model (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // bench commands
  input  wire logic       stream_on,
  input  wire logic       err_cmd,
  input  wire logic       tout_cmd,
  input  wire logic [7:0] count_cfg,
  // channel side
  input  wire logic       buf_swap,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_error,
  output logic            timeout_expired,
  output logic            ubm_buffer_pick,
  output logic [7:0]      desc_count
);
  logic [1:0] gap_q;
  logic [7:0] byte_q;

  assign desc_count = count_cfg;

  // one byte every fourth cycle; idle data toggles, never holds
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_q           <= 2'h0;
      byte_q          <= 8'h10;
      rx_valid        <= 1'b0;
      rx_data         <= 8'h00;
      rx_error        <= 1'b0;
      timeout_expired <= 1'b0;
      ubm_buffer_pick <= 1'b0;
    end else begin
      gap_q           <= gap_q + 2'h1;
      rx_valid        <= stream_on && gap_q == 2'h0;
      rx_data         <= (stream_on && gap_q == 2'h0) ? byte_q : ~rx_data;
      byte_q          <= byte_q + {7'h00, stream_on && gap_q == 2'h0};
      rx_error        <= err_cmd;
      timeout_expired <= tout_cmd;
      if (buf_swap) begin
        ubm_buffer_pick <= ~ubm_buffer_pick;
      end
    end
  end
endmodule // urd_far_model

// ==== verif/uart_rx_dma_channel_tb_top.sv ====
/*
  uart_rx_dma_channel_tb_top: directed bench for the receive channel.
  Assumes urd_pkg addresses and the far-side model urd_far_model.
*/
`timescale 1ns/10ps
module uart_rx_dma_channel_tb_top;
  import urd_pkg::*;
  localparam logic [15:0] CH = URD_CHDEF_ADDR;
  localparam logic [15:0] ST = URD_STAT_ADDR;
  localparam logic [15:0] MK = URD_MASK_ADDR;
  localparam logic [1:0]  OK = URD_RESP_OKAY;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, rx_valid, irq;
  logic        rx_error, timeout_expired, ubm_buffer_pick, buf_swap;
  logic        desc_wb_valid, nak_clear, sram_we, sram_buf_y;
  logic        stream_on, err_cmd, tout_cmd;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [7:0]  rx_data, desc_count, desc_wb_count, sram_data, count_cfg;
  logic [7:0]  wb_last;
  logic [2:0]  desc_sel;
  logic        bufs [0:255];
  logic [7:0]  dat [0:255];
  int          num_errors = 0, compares = 0, cyc = 0, n_we = 0, n_wb = 0;

  urd_rx_dma DUT (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid,
    .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .rx_valid, .rx_data, .rx_error, .timeout_expired,
    .ubm_buffer_pick, .buf_swap, .desc_count, .desc_sel, .desc_wb_valid,
    .desc_wb_count, .nak_clear, .sram_we, .sram_data, .sram_buf_y, .irq);

  urd_far_model far (.aclk, .aresetn, .stream_on, .err_cmd, .tout_cmd,
    .count_cfg, .buf_swap, .rx_valid, .rx_data, .rx_error,
    .timeout_expired, .ubm_buffer_pick, .desc_count);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // record stored bytes and write-backs; cut a hang short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (sram_we === 1'b1) begin
      bufs[n_we[7:0]] <= sram_buf_y;
      dat[n_we[7:0]]  <= sram_data;
      n_we            <= n_we + 1;
    end
    if (desc_wb_valid === 1'b1 && nak_clear === 1'b1) begin
      n_wb    <= n_wb + 1;
      wb_last <= desc_wb_count;
    end
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(er));
  endtask

  task automatic rdchk(input string nm, input logic [15:0] a,
                       input logic [7:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    chk("rresp", 32'(rresp), 32'(er));
    if (er == OK) chk(nm, 32'(rdata[7:0]), 32'(e));
  endtask

  task automatic pulse_wait(input bit err);
    int w0;
    w0 = n_wb;
    if (err) err_cmd <= 1'b1;
    else tout_cmd <= 1'b1;
    @(posedge aclk);
    err_cmd  <= 1'b0;
    tout_cmd <= 1'b0;
    while (n_wb == w0) @(posedge aclk);
    repeat (3) @(posedge aclk);
  endtask

  task automatic t_regs();
    rdchk("chdef_rst", CH, 8'h08, OK);
    wr(CH, 8'h15, OK);
    rdchk("chdef_rw", CH, 8'h1D, OK);
    chk("desc_sel", 32'(desc_sel), 32'h5);
    wr(16'h0100, 8'hFF, URD_RESP_DECERR);
    rdchk("unmapped", 16'h0100, 8'h00, URD_RESP_DECERR);
    rdchk("chdef_kept", CH, 8'h1D, OK);
  endtask

  task automatic t_burst(input logic pick);
    int b0;
    count_cfg <= 8'h03;
    wr(MK, 8'h01, OK);
    wr(CH, {3'b010, pick, 4'h2}, OK);
    b0 = n_we;
    wr(CH, {3'b110, pick, 4'h2}, OK);
    stream_on <= 1'b1;
    while (n_wb == 0 || n_we < b0 + 3) @(posedge aclk);
    repeat (12) @(posedge aclk);
    stream_on <= 1'b0;
    chk("burst_bytes", 32'(n_we - b0), 32'h3);
    chk("burst_buf", 32'(bufs[b0[7:0]]), 32'(pick));
    chk("burst_last", 32'(bufs[8'(b0 + 2)]), 32'(pick));
    chk("data", 32'(dat[8'(b0+2)]), 32'(8'(dat[b0[7:0]]+8'h02)));
    chk("wb_count", 32'(wb_last), 32'h0);
    chk("burst_irq", 32'(irq), 32'h1);
    rdchk("burst_off", CH, {3'b010, pick, 4'hA}, OK);
    rdchk("burst_stat", ST, 8'h11, OK);
    wr(ST, 8'h01, OK);
    repeat (2) @(posedge aclk);
    chk("irq_clear", 32'(irq), 32'h0);
  endtask

  task automatic t_cont();
    int b0;
    count_cfg <= 8'h02;
    wr(MK, 8'h03, OK);
    b0 = n_we;
    wr(CH, 8'hE0, OK);
    stream_on <= 1'b1;
    while (n_we < b0 + 6) @(posedge aclk);
    chk("pair", 32'(bufs[8'(b0 + 1)]), 32'(bufs[b0[7:0]]));
    chk("swap1", 32'(bufs[8'(b0 + 2)]), 32'(!bufs[b0[7:0]]));
    chk("swap2", 32'(bufs[8'(b0 + 4)]), 32'(bufs[b0[7:0]]));
    pulse_wait(1'b0);
    stream_on <= 1'b0;
    chk("tout_irq", 32'(irq), 32'h1);
    rdchk("tout_stat", ST, 8'h23, OK);
    wr(ST, 8'h03, OK);
    wr(CH, 8'hE0, OK);
    pulse_wait(1'b1);
    chk("err_irq", 32'(irq), 32'h0);
    rdchk("err_stat", ST, 8'h30, OK);
    rdchk("err_chdef", CH, {3'b011, ubm_buffer_pick, 4'h8}, OK);
  endtask

  task automatic t_keep();
    wr(MK, 8'h00, OK);
    wr(CH, 8'hA0, OK);
    tout_cmd <= 1'b1;
    @(posedge aclk);
    tout_cmd <= 1'b0;
    repeat (4) @(posedge aclk);
    rdchk("keep_en", CH, {3'b101, ubm_buffer_pick, 4'h8}, OK);
    wr(CH, 8'h20, OK);
    repeat (2) @(posedge aclk);
    chk("masked_irq", 32'(irq), 32'h0);
    rdchk("keep_stat", ST, 8'h32, OK);
  endtask

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {stream_on, err_cmd, tout_cmd} = 3'h0;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = 32'h00000000;
    count_cfg = 8'h00;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_burst(1'b0);
    t_burst(1'b1);
    t_cont();
    t_keep();
    complete_run();
  end
endmodule // uart_rx_dma_channel_tb_top
